// File: rtl/autoneg_register_set.sv
// Negotiation register set: advertisement, partner, expansion, setup.
// Assumes the arbitration logic and LED logic share clk; mdc/mdio are async pins.
`timescale 1ns/1ns
`include "autoneg_regs.svh"
module autoneg_register_set (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [4:0] phyAddrPins,
  input wire logic autonegEnable,
  input wire logic [15:0] partnerWord,
  input wire logic partnerPageValid,
  input wire logic parallelDetect100,
  input wire logic parallelDetect10,
  input wire logic multiLinkFault,
  input wire logic partnerNextPageCapable,
  input wire logic localNextPageCapable,
  input wire logic partnerNegotiationCapable,
  input wire logic abilityDetectEntered,
  input wire logic parallelFaultEntered,
  input wire logic linkCheckEntered,
  input wire logic linkPulse,
  input wire logic ledNormal,
  output logic [15:0] advertiseWord,
  output logic fourthLedOutput,
  output logic shortTimers,
  output logic negotiationLoopback
);

  // ******************************
  // Management slave
  // ******************************

  mgmt_if bus ();

  mdio_slave u_slave (
    .clk(clk),
    .reset(reset),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .phyAddrPins(phyAddrPins),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .bus(bus)
  );

  // ******************************
  // Register state
  // ******************************

  autoneg_pkg::an_state_t s, next;
  logic [15:0] advWord;
  logic [15:0] readValue;
  logic advWrite;
  logic setupWrite;
  logic lpaRead;

  assign advWrite = bus.writeStrobe && bus.regAddr == `AN_REG_ADV;
  assign setupWrite = bus.writeStrobe && bus.regAddr == `AN_REG_SETUP;
  assign lpaRead = bus.readStrobe && bus.regAddr == `AN_REG_LPA;

  // Next page, acknowledge, bit 12 and T4 are fixed zero
  assign advWord = {2'h0, s.rf, 1'b0, s.tx_pause_ability, s.pause, 1'b0, s.abil, s.sel};

  always_comb begin
    next = s;
    if (advWrite) begin
      next.rf = bus.writeData[`AN_B_RF];
      next.tx_pause_ability = bus.writeData[`AN_B_TFC];
      next.pause = bus.writeData[`AN_B_PAUSE];
      next.abil = bus.writeData[`AN_B_ABIL_HI:`AN_B_ABIL_LO];
      next.sel = bus.writeData[`AN_B_SEL_HI:0];
    end
    if (setupWrite) begin
      next.ledSel = bus.writeData[`AN_B_LED];
      next.fastTimers = bus.writeData[`AN_B_FAST];
      next.loopback = bus.writeData[`AN_B_LPBK];
    end
    // Whole received page, acknowledge and fault bits included
    if (partnerPageValid) begin
      next.lpa = partnerWord;
    end
    if (parallelDetect100) begin
      next.lpa[`AN_B_100TX] = 1'b1;
    end
    if (parallelDetect10) begin
      next.lpa[`AN_B_10T] = 1'b1;
    end
    // A page arriving with the clearing read stays flagged
    if (lpaRead) begin
      next.pageRx = 1'b0;
    end
    if (partnerPageValid) begin
      next.pageRx = 1'b1;
    end
    if (multiLinkFault) begin
      next.multi_link_fault = 1'b1;
    end
    next.lpNp = partnerNextPageCapable;
    next.npAble = localNextPageCapable;
    next.lpNw = partnerNegotiationCapable;
    next.flags = s.flags | {abilityDetectEntered, parallelFaultEntered, linkCheckEntered};
    next.advOut = autonegEnable ? advWord : 16'h0000;
    next.led = s.ledSel ? linkPulse : ledNormal;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.abil <= `AN_ABIL_RESET;
      s.sel <= `AN_SEL_CSMA;
      s.lpa <= `AN_LPA_RESET;
    end else begin
      s <= next;
    end
  end

  // ******************************
  // Read path
  // ******************************

  always_comb begin
    case (bus.regAddr)
      `AN_REG_ADV: readValue = advWord;
      `AN_REG_LPA: readValue = s.lpa;
      `AN_REG_EXP: readValue = {11'h000, s.multi_link_fault, s.lpNp, s.npAble, s.pageRx, s.lpNw};
      `AN_REG_SETUP: readValue = {4'h0, s.ledSel, s.fastTimers, s.loopback, 6'h00, s.flags};
      default: readValue = 16'h0000;
    endcase
  end

  assign bus.readData = readValue;

  assign advertiseWord = s.advOut;
  assign fourthLedOutput = s.led;
  assign shortTimers = s.fastTimers;
  assign negotiationLoopback = s.loopback;

  // ******************************
  // Checks
  // ******************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_ADV_SENT: assert property (autonegEnable |=> advertiseWord == $past(advWord))
    else $error("advertised word differs from register");
  AST_ADV_RO: assert property (advWrite |=> advertiseWord[15:14] == 2'h0 && advWord[9] == 1'b0)
    else $error("read-only advertise bit changed");
  AST_ADV_RF: assert property (advWrite |=> s.rf == $past(bus.writeData[`AN_B_RF]))
    else $error("remote fault ability not written");
  AST_ADV_ABIL: assert property (advWrite |=> advWord[`AN_B_ABIL_HI:`AN_B_ABIL_LO] ==
      $past(bus.writeData[`AN_B_ABIL_HI:`AN_B_ABIL_LO]))
    else $error("ability bits not written");
  AST_ADV_PAUSE: assert property (advWrite |=> advWord[`AN_B_TFC:`AN_B_PAUSE] ==
      $past(bus.writeData[`AN_B_TFC:`AN_B_PAUSE]))
    else $error("pause abilities not written");
  AST_ADV_SEL: assert property (advWrite ##1 autonegEnable |=> advertiseWord[4:0] ==
      $past(bus.writeData[4:0], 2))
    else $error("selector not advertised");
  AST_LPA_CAPTURE: assert property (partnerPageValid && !parallelDetect100 && !parallelDetect10
      |=> s.lpa == $past(partnerWord))
    else $error("partner word not captured");
  AST_LPA_RO: assert property (bus.writeStrobe && bus.regAddr == `AN_REG_LPA && !partnerPageValid &&
      !parallelDetect100 && !parallelDetect10 |=> s.lpa == $past(s.lpa))
    else $error("partner register changed by a write");
  AST_PD100: assert property (parallelDetect100 |=> s.lpa[`AN_B_100TX])
    else $error("parallel detect 100 not shown");
  AST_PD10: assert property (parallelDetect10 |=> s.lpa[`AN_B_10T])
    else $error("parallel detect 10 not shown");
  AST_EXP_ZERO: assert property (bus.regAddr == `AN_REG_EXP |-> readValue[15:5] == 11'h000)
    else $error("expansion reserved bits not zero");
  AST_MLF: assert property (multiLinkFault |=> s.multi_link_fault [*3])
    else $error("multiple link fault not sticky");
  AST_PAGE_SET: assert property (partnerPageValid |=> s.pageRx)
    else $error("page received not flagged");
  AST_PAGE_CLR: assert property (lpaRead && !partnerPageValid |=> !s.pageRx)
    else $error("page flag not cleared by read");
  AST_LED: assert property (s.ledSel && !setupWrite |=> fourthLedOutput == $past(linkPulse))
    else $error("LED not following link pulses");
  AST_FLAGS: assert property (abilityDetectEntered |=> s.flags[2] ##4 s.flags[2])
    else $error("ability detect flag not sticky");
  AST_NEG_OFF: assert property (!autonegEnable |=> advertiseWord == 16'h0000)
    else $error("advertising while negotiation disabled");
  AST_EXP_COPY: assert property (!$past(reset) |-> s.lpNp == $past(partnerNextPageCapable) &&
      s.npAble == $past(localNextPageCapable) && s.lpNw == $past(partnerNegotiationCapable))
    else $error("expansion status not copied");
  AST_STICKY: assert property (1'b1 |=> (s.flags & $past(s.flags)) == $past(s.flags) &&
      (s.multi_link_fault || !$past(s.multi_link_fault)))
    else $error("sticky status bit cleared");
  AST_SETUP_OUT: assert property (setupWrite |=> shortTimers == $past(bus.writeData[`AN_B_FAST]) &&
      negotiationLoopback == $past(bus.writeData[`AN_B_LPBK]))
    else $error("setup controls not applied");
  AST_LED_NORMAL: assert property (!s.ledSel |=> fourthLedOutput == $past(ledNormal))
    else $error("LED not following normal drive");

  COV_WRITE_ADV: cover property (advWrite ##[1:20] autonegEnable);
  COV_PAGE_READ: cover property (partnerPageValid ##[1:500] lpaRead);
  COV_PD: cover property (parallelDetect100 ##[1:50] parallelDetect10);
  COV_SETUP: cover property (setupWrite ##1 s.fastTimers && s.loopback);

endmodule

// File: rtl/autoneg_regs.svh
// How it works
// - Advertisement register content is the sent word
// - Next-page, acknowledge, T4 advertise bits read zero
// - Advertise bit 13 writable remote fault capability
// - Advertise bits 11, 10 writable pause abilities
// - Advertise bits 8..5 writable, reset one
// - Partner register read-only, captures received word
// - Partner word updated per page; bit 15 kind
// - Partner bits 14, 13: acknowledge, remote fault
// - Partner bits 11, 10: partner pause abilities
// - Partner bit 7 resets one, parallel detect sets
// - Partner bit 5 resets zero, parallel detect sets
// - Partner bits 9, 8, 6, selector reset zero
// - Expansion bits 15..5 always read zero
// - Expansion bit 4 sticky multiple link fault
// - Expansion bits 3, 2 next-page abilities
// - Page-received bit, cleared by partner register read
// - Expansion bit 0 partner negotiation capable
// - Setup bit 11 routes link pulses to LED
// - Setup bit 10 shortens negotiation timers
// - Setup bit 9 negotiation loopback
// - Setup bits 2..0 sticky state-visited flags
// - Serial management access at strapped address
// - Advertisement used only with negotiation enabled
//
// Register offsets, field positions, reset values and frame counts.
// Assumes a 5-bit register address from the serial management frame.
`ifndef AUTONEG_REGS_SVH
`define AUTONEG_REGS_SVH

`define AN_REG_ADV 5'h04
`define AN_REG_LPA 5'h05
`define AN_REG_EXP 5'h06
`define AN_REG_SETUP 5'h10

`define AN_ABIL_RESET 4'hF
`define AN_SEL_CSMA 5'h01
`define AN_LPA_RESET 16'h0080

`define AN_B_RF 13
`define AN_B_TFC 11
`define AN_B_PAUSE 10
`define AN_B_ABIL_HI 8
`define AN_B_ABIL_LO 5
`define AN_B_SEL_HI 4
`define AN_B_100TX 7
`define AN_B_10T 5
`define AN_B_LED 11
`define AN_B_FAST 10
`define AN_B_LPBK 9

`define MDIO_PREAMBLE_LEN 6'h20
`define MDIO_HDR_LAST 5'h0C
`define MDIO_DATA_BITS 5'h10
`define MDIO_WR_LAST 5'h11
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_ADDR_AGE 2'h2

`endif

// File: rtl/autoneg_pkg.sv
// Types for the negotiation register set and its management slave.
// Assumes nothing beyond a SystemVerilog compiler.
package autoneg_pkg;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_HDR = 3'h1,
    PH_RTA = 3'h2,
    PH_RDATA = 3'h3,
    PH_WDATA = 3'h4
  } mdio_phase_t;

  typedef struct packed {
    logic mdcMeta;
    logic mdcSync;
    logic mdcLast;
    logic dMeta;
    logic dSync;
    logic [4:0] aMeta;
    logic [4:0] aSync;
    logic [1:0] addrAge;
    logic [4:0] myAddr;
    mdio_phase_t phase;
    logic [5:0] ones;
    logic preambleSeen;
    logic [4:0] cnt;
    logic [15:0] shift;
    logic isWrite;
    logic [4:0] regAddr;
    logic readStrobe;
    logic writeStrobe;
    logic [15:0] writeData;
    logic mdioOut;
    logic mdioOe;
  } mdio_state_t;

  typedef struct packed {
    logic rf;
    logic tx_pause_ability;
    logic pause;
    logic [3:0] abil;
    logic [4:0] sel;
    logic [15:0] lpa;
    logic multi_link_fault;
    logic lpNp;
    logic npAble;
    logic pageRx;
    logic lpNw;
    logic ledSel;
    logic fastTimers;
    logic loopback;
    logic [2:0] flags;
    logic [15:0] advOut;
    logic led;
  } an_state_t;

endpackage

// File: rtl/mgmt_if.sv
// Register access strobes between the management slave and the register set.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface mgmt_if;
  logic [4:0] regAddr;
  logic readStrobe;
  logic writeStrobe;
  logic [15:0] writeData;
  logic [15:0] readData;

  modport slave (output regAddr, output readStrobe, output writeStrobe, output writeData, input readData);
  modport regs (input regAddr, input readStrobe, input writeStrobe, input writeData, output readData);
endinterface

// File: rtl/mdio_slave.sv
// Serial management slave: samples the management clock, decodes frames.
// Assumes clk runs well above the management clock rate.
`timescale 1ns/1ns
`include "autoneg_regs.svh"
module mdio_slave #(
  parameter logic [5:0] PREAMBLE_LEN = `MDIO_PREAMBLE_LEN
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdioIn,
  input wire logic [4:0] phyAddrPins,
  output logic mdioOut,
  output logic mdioOe,
  mgmt_if.slave bus
);

  generate
    if (PREAMBLE_LEN == 6'h00) begin : g_bad
      $error("PREAMBLE_LEN must be at least one");
    end
  endgenerate

  autoneg_pkg::mdio_state_t s, next;
  logic rise;
  logic [12:0] hdr;
  logic match;

  assign rise = s.mdcSync & ~s.mdcLast;

  always_comb begin
    hdr = {s.shift[11:0], s.dSync};
    match = hdr[12] && (hdr[9:5] == s.myAddr);
    next = s;
    next.mdcMeta = mdc;
    next.mdcSync = s.mdcMeta;
    next.mdcLast = s.mdcSync;
    next.dMeta = mdioIn;
    next.dSync = s.dMeta;
    next.aMeta = phyAddrPins;
    next.aSync = s.aMeta;
    next.readStrobe = 1'b0;
    next.writeStrobe = 1'b0;
    // Strap capture once the pins have passed the synchroniser
    if (s.addrAge != 2'h3) begin
      next.addrAge = s.addrAge + 2'h1;
    end
    if (s.addrAge == `MDIO_ADDR_AGE) begin
      next.myAddr = s.aSync;
    end
    if (rise) begin
      unique case (s.phase)
        autoneg_pkg::PH_IDLE: begin
          if (s.dSync) begin
            if (s.ones != PREAMBLE_LEN) begin
              next.ones = s.ones + 6'h01;
            end
            if (s.ones == PREAMBLE_LEN - 6'h01) begin
              next.preambleSeen = 1'b1;
            end
          end else if (s.preambleSeen && s.ones != 6'h00) begin
            next.phase = autoneg_pkg::PH_HDR;
            next.cnt = 5'h00;
          end else begin
            next.ones = 6'h00;
          end
        end
        autoneg_pkg::PH_HDR: begin
          next.shift = {s.shift[14:0], s.dSync};
          next.cnt = s.cnt + 5'h01;
          if (s.cnt == `MDIO_HDR_LAST) begin
            next.cnt = 5'h00;
            next.ones = 6'h00;
            next.regAddr = hdr[4:0];
            if (match && hdr[11:10] == `MDIO_OP_READ) begin
              next.phase = autoneg_pkg::PH_RTA;
            end else begin
              next.phase = autoneg_pkg::PH_WDATA;
              next.isWrite = match && (hdr[11:10] == `MDIO_OP_WRITE);
            end
          end
        end
        autoneg_pkg::PH_RTA: begin
          // Drive turnaround zero, snapshot the register
          next.mdioOe = 1'b1;
          next.mdioOut = 1'b0;
          next.shift = bus.readData;
          next.readStrobe = 1'b1;
          next.phase = autoneg_pkg::PH_RDATA;
        end
        autoneg_pkg::PH_RDATA: begin
          if (s.cnt == `MDIO_DATA_BITS) begin
            next.mdioOe = 1'b0;
            next.mdioOut = 1'b0;
            next.phase = autoneg_pkg::PH_IDLE;
          end else begin
            next.mdioOut = s.shift[15];
            next.shift = {s.shift[14:0], 1'b0};
            next.cnt = s.cnt + 5'h01;
          end
        end
        autoneg_pkg::PH_WDATA: begin
          // Turnaround plus data; frames for others are skipped here
          next.shift = {s.shift[14:0], s.dSync};
          next.cnt = s.cnt + 5'h01;
          if (s.cnt == `MDIO_WR_LAST) begin
            next.phase = autoneg_pkg::PH_IDLE;
            next.writeStrobe = s.isWrite;
            next.writeData = {s.shift[14:0], s.dSync};
          end
        end
        default: begin
          next.phase = autoneg_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next;
    end
  end

  assign mdioOut = s.mdioOut;
  assign mdioOe = s.mdioOe;
  assign bus.regAddr = s.regAddr;
  assign bus.readStrobe = s.readStrobe;
  assign bus.writeStrobe = s.writeStrobe;
  assign bus.writeData = s.writeData;

  // ******************************
  // Checks
  // ******************************

  AST_DRIVE_READ: assert property (@(posedge clk) disable iff (reset)
      s.mdioOe |-> s.phase == autoneg_pkg::PH_RDATA)
    else $error("management data driven outside a read");

endmodule

// File: verif/mdio_master_model.sv
// Management master model: drives serial frames on mdc and mdio.
// Assumes the bench resolves the mdio wire with a pull-up.
`timescale 1ns/1ns
module mdio_master_model (
  input wire logic mdioWire,
  output logic mdc,
  output logic macOut,
  output logic macOe,
  output logic rdDone,
  output logic [15:0] rdData
);
  logic smp;

  initial begin
    mdc = 1'b0;
    macOut = 1'b1;
    macOe = 1'b0;
    rdDone = 1'b0;
    rdData = 16'h0000;
    smp = 1'b1;
  end

  // ********************
  // One bit, one frame
  // ********************
  task automatic bitOut(input logic b, input logic oe);
    mdc = 1'b0;
    macOe = oe;
    macOut = b;
    #200;
    mdc = 1'b1;
    smp = mdioWire;
    #200;
  endtask

  // Clock stands low between frames
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] hdr;
    hdr = {2'h1, rd ? 2'h2 : 2'h1, phy, ra, 2'h2, wd};
    #11;
    repeat (32) bitOut(1'b1, 1'b1);
    for (int i = 31; i >= 0; i--) begin
      bitOut(hdr[i], !(rd && i < 18));
      if (rd && i < 16) rdData[i] = smp;
    end
    mdc = 1'b0;
    macOe = 1'b0;
    macOut = 1'b1;
    if (rd) begin
      rdDone = 1'b1;
      #1;
      rdDone = 1'b0;
    end
  endtask
endmodule

// File: verif/test_autoneg_register_set.sv
// Self-checking bench for the negotiation register set.
// Assumes the management master model and a pulled-up mdio wire.
`timescale 1ns/1ns
module test_autoneg_register_set;
  logic clk, reset, mdc, mdioOut, mdioOe, macOut, macOe, rdDone, mdioWire;
  logic autonegEnable, partnerPageValid, parallelDetect100, parallelDetect10;
  logic multiLinkFault, partnerNextPageCapable, localNextPageCapable;
  logic partnerNegotiationCapable, abilityDetectEntered, parallelFaultEntered;
  logic linkCheckEntered, linkPulse, ledNormal, fourthLedOutput, shortTimers, negotiationLoopback;
  logic [4:0] phy;
  logic [15:0] partnerWord, advertiseWord, rdData, r;
  logic [15:0] expQ[$];
  int fails = 0;
  int nTests = 0;

  assign mdioWire = mdioOe ? mdioOut : (macOe ? macOut : 1'b1);

  autoneg_register_set u_dut (.clk(clk), .reset(reset), .mdc(mdc), .mdioIn(mdioWire),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddrPins(phy), .autonegEnable(autonegEnable),
    .partnerWord(partnerWord), .partnerPageValid(partnerPageValid),
    .parallelDetect100(parallelDetect100), .parallelDetect10(parallelDetect10),
    .multiLinkFault(multiLinkFault), .partnerNextPageCapable(partnerNextPageCapable),
    .localNextPageCapable(localNextPageCapable), .partnerNegotiationCapable(partnerNegotiationCapable),
    .abilityDetectEntered(abilityDetectEntered), .parallelFaultEntered(parallelFaultEntered),
    .linkCheckEntered(linkCheckEntered), .linkPulse(linkPulse), .ledNormal(ledNormal),
    .advertiseWord(advertiseWord), .fourthLedOutput(fourthLedOutput), .shortTimers(shortTimers),
    .negotiationLoopback(negotiationLoopback));

  mdio_master_model u_mac (.mdioWire(mdioWire), .mdc(mdc), .macOut(macOut), .macOe(macOe),
    .rdDone(rdDone), .rdData(rdData));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ********************
  // Helpers
  // ********************
  task automatic close_out;
    $display("compared %0d, mismatched %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic miss(input logic [15:0] got, input logic [15:0] e);
    fails++;
    $display("unexpected at %0t: got %h expected %h", $time, got, e);
  endtask

  task automatic cmp_read(input logic [15:0] got, input logic [15:0] e);
    nTests++;
    if (got !== e) miss(got, e);
  endtask

  task automatic cmp_port(input logic [15:0] got, input logic [15:0] e);
    nTests++;
    if (got !== e) miss(got, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic rd(input logic [4:0] a, input logic [4:0] ra, input logic [15:0] e);
    expQ.push_back(e);
    u_mac.frame(1'b1, a, ra, 16'h0000);
    tick(1);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_mac.frame(1'b0, phy, ra, d);
    tick(6);
  endtask

  task automatic page(input logic [15:0] w);
    partnerWord = w;
    partnerPageValid = 1'b1;
    tick(1);
    partnerPageValid = 1'b0;
    tick(1);
  endtask

  // Read results against the oldest note
  initial forever begin
    @(posedge rdDone);
    if (expQ.size() == 0) miss(rdData, 16'h0000);
    else cmp_read(rdData, expQ.pop_front());
  end

  initial begin
    #3000000;
    fails++;
    close_out();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    {reset, autonegEnable, partnerPageValid, parallelDetect100, parallelDetect10} = 5'h10;
    {multiLinkFault, partnerNextPageCapable, localNextPageCapable, partnerNegotiationCapable} = 4'h0;
    {abilityDetectEntered, parallelFaultEntered, linkCheckEntered, linkPulse, ledNormal} = 5'h00;
    partnerWord = 16'h0000;
    void'($urandom(32'h0a30bcbf));
    phy = 5'($urandom);
    tick(10);
    reset = 1'b0;
    tick(12);
    rd(phy, 5'h04, 16'h01E1);
    rd(phy, 5'h05, 16'h0080);
    rd(phy, 5'h06, 16'h0000);
    rd(phy, 5'h10, 16'h0000);
    rd(phy, 5'h07, 16'h0000);
    rd(phy ^ 5'h01, 5'h04, 16'hFFFF);
    cmp_port(advertiseWord, 16'h0000);
    $display("test reset values done");
    wr(5'h04, 16'hFFFF);
    rd(phy, 5'h04, 16'h2DFF);
    r = 16'($urandom);
    wr(5'h04, r);
    rd(phy, 5'h04, r & 16'h2DFF);
    autonegEnable = 1'b1;
    tick(2);
    cmp_port(advertiseWord, r & 16'h2DFF);
    wr(5'h04, 16'h21E1);
    cmp_port(advertiseWord, 16'h21E1);
    autonegEnable = 1'b0;
    tick(2);
    cmp_port(advertiseWord, 16'h0000);
    $display("test advertisement done");
    wr(5'h10, 16'hFFFF);
    rd(phy, 5'h10, 16'h0E00);
    linkPulse = 1'b1;
    tick(2);
    cmp_port({13'h0, fourthLedOutput, shortTimers, negotiationLoopback}, 16'h0007);
    wr(5'h10, 16'h0000);
    ledNormal = 1'b1;
    tick(2);
    cmp_port({13'h0, fourthLedOutput, shortTimers, negotiationLoopback}, 16'h0004);
    $display("test setup controls done");
    r = 16'($urandom);
    page(r);
    rd(phy, 5'h06, 16'h0002);
    rd(phy, 5'h05, r);
    wr(5'h05, ~r);
    rd(phy, 5'h05, r);
    rd(phy, 5'h06, 16'h0000);
    page(16'h0000);
    parallelDetect100 = 1'b1;
    tick(1);
    parallelDetect100 = 1'b0;
    rd(phy, 5'h05, 16'h0080);
    parallelDetect10 = 1'b1;
    tick(1);
    parallelDetect10 = 1'b0;
    rd(phy, 5'h05, 16'h00A0);
    $display("test partner word done");
    {partnerNextPageCapable, partnerNegotiationCapable, multiLinkFault} = 3'h7;
    tick(1);
    multiLinkFault = 1'b0;
    rd(phy, 5'h06, 16'h0019);
    {partnerNextPageCapable, localNextPageCapable, partnerNegotiationCapable} = 3'h2;
    tick(1);
    rd(phy, 5'h06, 16'h0014);
    abilityDetectEntered = 1'b1;
    tick(1);
    abilityDetectEntered = 1'b0;
    rd(phy, 5'h10, 16'h0004);
    {parallelFaultEntered, linkCheckEntered} = 2'h3;
    tick(1);
    {parallelFaultEntered, linkCheckEntered} = 2'h0;
    wr(5'h10, 16'h0000);
    rd(phy, 5'h10, 16'h0007);
    $display("test status flags done");
    tick(2);
    if (expQ.size() != 0) miss(16'(expQ.size()), 16'h0000);
    close_out();
  end
endmodule
